// *** rtl/adctc_regs.svh ***
`ifndef ADCTC_REGS_SVH
`define ADCTC_REGS_SVH
// Notes on behaviour
// - Source step bit two: fixed or increment
// - Source step ignored when repeat at source
// - Repeat select: zero destination, one source
// - Mode bit: normal or repeat; normal ignores select
// - Block size 00H means 256 units
// - Transfer count 00H means 256 activations
// - Reload register restores count in repeat mode
// - Sixteen bit source and destination addresses
// - Activation enable bit five gates conversion trigger
// - Activation enable cleared on transfer end condition
// - Request flag set on request; software clears
// - Mask bit zero blocks request flag interrupt when one; event status interrupts pass
// - Run control bit seven starts and stops
// - Run bit reads one through wait and conversion
// - Size bit: zero bytes, one halfwords
// - Chain enable bit stored but unused; no chaining
`define ADCTC_OFS_CTRL     8'h00
`define ADCTC_OFS_BLKSZ    8'h01
`define ADCTC_OFS_COUNT    8'h02
`define ADCTC_OFS_RELOAD   8'h03
`define ADCTC_OFS_SRC_LO   8'h04
`define ADCTC_OFS_SRC_HI   8'h05
`define ADCTC_OFS_DST_LO   8'h06
`define ADCTC_OFS_DST_HI   8'h07
`define ADCTC_OFS_ACTEN    8'h08
`define ADCTC_OFS_IRQF     8'h09
`define ADCTC_OFS_IRQM     8'h0A
`define ADCTC_OFS_MODE0    8'h0B
`define ADCTC_OFS_EVSTAT   8'h0C
`define ADCTC_OFS_EVMASK   8'h0D
`define ADCTC_BIT_MODE     0
`define ADCTC_BIT_REPEAT_AREA_SELECT   1
`define ADCTC_BIT_SRCSTEP  2
`define ADCTC_BIT_DSTSTEP  3
`define ADCTC_BIT_CHAIN    4
`define ADCTC_BIT_SIZE     6
`define ADCTC_BIT_ACTEN    5
`define ADCTC_BIT_CEFLAG   0
`define ADCTC_BIT_CEMASK   0
`define ADCTC_BIT_RUN      7
`define ADCTC_BIT_CMPEN    0
`define ADCTC_RST_BYTE     8'h00
`define ADCTC_RST_MASK     8'hFF
`define ADCTC_STAB_NS      1000
`define ADCTC_CLK_NS       40
`define ADCTC_STAB_CYC     ((`ADCTC_STAB_NS + `ADCTC_CLK_NS - 1) / `ADCTC_CLK_NS)
`endif

// *** rtl/adctc_pkg.sv ***
package adctc_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} adctc_bus_t;
	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        wide;
	} adctc_mem_t;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_READ  = 4'b0010,
		ST_WRITE = 4'b0100,
		ST_DONE  = 4'b1000
	} adctc_state_t;
endpackage

// *** rtl/adctc_rst_sync.sv ***
module adctc_rst_sync (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	output logic      rst_sync_n
);
	logic meta_ff;
	// Release is synchronous so no flop sees a runt reset edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff    <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			meta_ff    <= 1'b1;
			rst_sync_n <= meta_ff;
		end
	end
endmodule

// *** rtl/adctc_channel.sv ***
`include "adctc_regs.svh"
module adctc_channel (
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	input  wire adctc_pkg::adctc_bus_t bus_in,
	output logic [7:0]               rdata_ff,
	input  wire logic                conv_end,
	input  wire logic                mem_ack,
	input  wire logic [15:0]         mem_rdata,
	output adctc_pkg::adctc_mem_t    mem_ff,
	output logic                     irq_ff,
	output logic                     xfer_end_ff,
	output logic                     run_ff
);
	logic                   rst_i_n;
	logic                   ce_meta_ff;
	logic                   ce_sync_ff;
	logic                   ce_prev_ff;
	logic                   ce_rise;
	logic [7:0]             ctrl_ff;
	logic [7:0]             blksz_ff;
	logic [7:0]             count_ff;
	logic [7:0]             reload_ff;
	logic [15:0]            src_ff;
	logic [15:0]            dst_ff;
	logic [15:0]            src_base_ff;
	logic [15:0]            dst_base_ff;
	logic [7:0]             acten_ff;
	logic [7:0]             irqf_ff;
	logic [7:0]             irqm_ff;
	logic [7:0]             mode0_ff;
	logic [1:0]             evstat_ff;
	logic [1:0]             evmask_ff;
	logic [8:0]             units_ff;
	logic [15:0]            data_ff;
	logic [7:0]             stab_ff;
	logic                   converting_ff;
	adctc_pkg::adctc_state_t state_ff;
	adctc_pkg::adctc_state_t nxt_state;
	logic                   wr_hit;
	logic                   start;
	logic                   blk_last;
	logic                   cnt_last;
	logic                   is_rpt;
	logic                   rpt_src;
	logic                   src_inc;
	logic                   end_cond;
	logic [1:0]             ev_set;
	logic [15:0]            step;

	adctc_rst_sync u_rst (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.rst_sync_n (rst_i_n)
	);

	function automatic logic [8:0] units_of(input logic [7:0] v);
		units_of = (v == 8'h00) ? 9'h100 : {1'b0, v};
	endfunction

	// Conversion-end pin crosses in through two flops
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			ce_meta_ff <= 1'b0;
			ce_sync_ff <= 1'b0;
			ce_prev_ff <= 1'b0;
		end else begin
			ce_meta_ff <= conv_end;
			ce_sync_ff <= ce_meta_ff;
			ce_prev_ff <= ce_sync_ff;
		end
	end
	assign ce_rise = ce_sync_ff && !ce_prev_ff;

	assign is_rpt   = ctrl_ff[`ADCTC_BIT_MODE];
	assign rpt_src  = is_rpt && ctrl_ff[`ADCTC_BIT_REPEAT_AREA_SELECT];
	// Repeat area at the source always steps; its step bit has no say
	assign src_inc  = ctrl_ff[`ADCTC_BIT_SRCSTEP] || rpt_src;
	assign step     = ctrl_ff[`ADCTC_BIT_SIZE] ? 16'h0002 : 16'h0001;
	assign blk_last = (units_ff == 9'h001);
	assign cnt_last = (count_ff == 8'h01);
	assign end_cond = (state_ff == adctc_pkg::ST_DONE) && cnt_last && !is_rpt;
	// Trigger only when activation enabled and run bit set
	assign start    = ce_rise && acten_ff[`ADCTC_BIT_ACTEN] && mode0_ff[`ADCTC_BIT_RUN];
	assign wr_hit   = bus_in.wr;
	assign ev_set   = {end_cond, ce_rise};

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			adctc_pkg::ST_IDLE:  if (start) nxt_state = adctc_pkg::ST_READ;
			adctc_pkg::ST_READ:  if (mem_ack) nxt_state = adctc_pkg::ST_WRITE;
			adctc_pkg::ST_WRITE: if (mem_ack) begin
				nxt_state = blk_last ? adctc_pkg::ST_DONE : adctc_pkg::ST_READ;
			end
			adctc_pkg::ST_DONE:  nxt_state = adctc_pkg::ST_IDLE;
			default:             nxt_state = adctc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			state_ff <= adctc_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Memory request held until acknowledged
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			mem_ff  <= '0;
			data_ff <= 16'h0000;
		end else begin
			mem_ff.wide <= ctrl_ff[`ADCTC_BIT_SIZE];
			case (nxt_state)
				adctc_pkg::ST_READ: begin
					mem_ff.req  <= 1'b1;
					mem_ff.we   <= 1'b0;
					mem_ff.addr <= src_ff;
				end
				adctc_pkg::ST_WRITE: begin
					mem_ff.req   <= 1'b1;
					mem_ff.we    <= 1'b1;
					mem_ff.addr  <= dst_ff;
					mem_ff.wdata <= (state_ff == adctc_pkg::ST_READ) ? mem_rdata : data_ff;
				end
				default: mem_ff.req <= 1'b0;
			endcase
			if (state_ff == adctc_pkg::ST_READ && mem_ack) begin
				data_ff <= mem_rdata;
			end
		end
	end

	// Block, count and address progress
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			units_ff    <= 9'h000;
			src_ff      <= 16'h0000;
			dst_ff      <= 16'h0000;
			src_base_ff <= 16'h0000;
			dst_base_ff <= 16'h0000;
			count_ff    <= `ADCTC_RST_BYTE;
		end else begin
			if (wr_hit && bus_in.addr == `ADCTC_OFS_SRC_LO) begin
				src_ff[7:0]      <= bus_in.wdata;
				src_base_ff[7:0] <= bus_in.wdata;
			end
			if (wr_hit && bus_in.addr == `ADCTC_OFS_SRC_HI) begin
				src_ff[15:8]      <= bus_in.wdata;
				src_base_ff[15:8] <= bus_in.wdata;
			end
			if (wr_hit && bus_in.addr == `ADCTC_OFS_DST_LO) begin
				dst_ff[7:0]      <= bus_in.wdata;
				dst_base_ff[7:0] <= bus_in.wdata;
			end
			if (wr_hit && bus_in.addr == `ADCTC_OFS_DST_HI) begin
				dst_ff[15:8]      <= bus_in.wdata;
				dst_base_ff[15:8] <= bus_in.wdata;
			end
			if (wr_hit && bus_in.addr == `ADCTC_OFS_COUNT) begin
				count_ff <= bus_in.wdata;
			end
			if (start && state_ff == adctc_pkg::ST_IDLE) begin
				units_ff <= units_of(blksz_ff);
			end
			if (state_ff == adctc_pkg::ST_READ && mem_ack && src_inc) begin
				src_ff <= src_ff + step;
			end
			if (state_ff == adctc_pkg::ST_WRITE && mem_ack) begin
				units_ff <= units_ff - 9'h001;
				if (!rpt_src) begin
					dst_ff <= dst_ff + step;
				end
			end
			if (state_ff == adctc_pkg::ST_DONE) begin
				count_ff <= count_ff - 8'h01;
				// Repeat area keeps moving until the count expires, then returns
				if (is_rpt && rpt_src && cnt_last) begin
					src_ff <= src_base_ff;
				end
				if (is_rpt && !rpt_src && cnt_last) begin
					dst_ff <= dst_base_ff;
				end
				if (is_rpt && cnt_last) begin
					count_ff <= reload_ff;
				end
			end
		end
	end

	// Software registers; hardware clears win only where defined
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			ctrl_ff   <= `ADCTC_RST_BYTE;
			blksz_ff  <= `ADCTC_RST_BYTE;
			reload_ff <= `ADCTC_RST_BYTE;
			acten_ff  <= `ADCTC_RST_BYTE;
			irqm_ff   <= `ADCTC_RST_MASK;
		end else begin
			if (wr_hit) begin
				case (bus_in.addr)
					`ADCTC_OFS_CTRL:   ctrl_ff   <= bus_in.wdata & 8'h5F;
					`ADCTC_OFS_BLKSZ:  blksz_ff  <= bus_in.wdata;
					`ADCTC_OFS_RELOAD: reload_ff <= bus_in.wdata;
					`ADCTC_OFS_ACTEN:  acten_ff  <= bus_in.wdata;
					`ADCTC_OFS_IRQM:   irqm_ff   <= bus_in.wdata;
					default: ;
				endcase
			end
			if (end_cond) begin
				acten_ff[`ADCTC_BIT_ACTEN] <= 1'b0;
			end
		end
	end

	// Request flag: write 0 clears, hardware set wins
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			irqf_ff   <= `ADCTC_RST_BYTE;
			evstat_ff <= 2'b00;
			evmask_ff <= 2'b00;
		end else begin
			if (wr_hit && bus_in.addr == `ADCTC_OFS_IRQF) begin
				irqf_ff <= bus_in.wdata & irqf_ff;
			end
			if (ce_rise) begin
				irqf_ff[`ADCTC_BIT_CEFLAG] <= 1'b1;
			end
			if (wr_hit && bus_in.addr == `ADCTC_OFS_EVMASK) begin
				evmask_ff <= bus_in.wdata[1:0];
			end
			evstat_ff <= (evstat_ff
				& ~((wr_hit && bus_in.addr == `ADCTC_OFS_EVSTAT) ? bus_in.wdata[1:0] : 2'b00))
				| ev_set;
		end
	end

	// Converter run bit reads 1 only while waiting or converting
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			mode0_ff      <= `ADCTC_RST_BYTE;
			stab_ff       <= 8'h00;
			converting_ff <= 1'b0;
		end else begin
			if (wr_hit && bus_in.addr == `ADCTC_OFS_MODE0) begin
				mode0_ff <= bus_in.wdata;
				stab_ff  <= bus_in.wdata[`ADCTC_BIT_RUN] ? 8'(`ADCTC_STAB_CYC) : 8'h00;
			end else if (stab_ff != 8'h00) begin
				stab_ff <= stab_ff - 8'h01;
			end
			converting_ff <= mode0_ff[`ADCTC_BIT_RUN] && stab_ff == 8'h00;
		end
	end

	// Read mux; data appear one cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			rdata_ff <= 8'h00;
		end else if (bus_in.rd) begin
			case (bus_in.addr)
				`ADCTC_OFS_CTRL:   rdata_ff <= ctrl_ff;
				`ADCTC_OFS_BLKSZ:  rdata_ff <= blksz_ff;
				`ADCTC_OFS_COUNT:  rdata_ff <= count_ff;
				`ADCTC_OFS_RELOAD: rdata_ff <= reload_ff;
				`ADCTC_OFS_SRC_LO: rdata_ff <= src_ff[7:0];
				`ADCTC_OFS_SRC_HI: rdata_ff <= src_ff[15:8];
				`ADCTC_OFS_DST_LO: rdata_ff <= dst_ff[7:0];
				`ADCTC_OFS_DST_HI: rdata_ff <= dst_ff[15:8];
				`ADCTC_OFS_ACTEN:  rdata_ff <= acten_ff;
				`ADCTC_OFS_IRQF:   rdata_ff <= irqf_ff;
				`ADCTC_OFS_IRQM:   rdata_ff <= irqm_ff;
				`ADCTC_OFS_MODE0:  rdata_ff <= mode0_ff;
				`ADCTC_OFS_EVSTAT: rdata_ff <= {6'h00, evstat_ff};
				`ADCTC_OFS_EVMASK: rdata_ff <= {6'h00, evmask_ff};
				default:           rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	// Outputs
	always_ff @(posedge clk_sys or negedge rst_i_n) begin
		if (!rst_i_n) begin
			irq_ff      <= 1'b0;
			xfer_end_ff <= 1'b0;
			run_ff      <= 1'b0;
		end else begin
			irq_ff      <= |(evstat_ff & evmask_ff)
				|| (irqf_ff[`ADCTC_BIT_CEFLAG] && !irqm_ff[`ADCTC_BIT_CEMASK]);
			xfer_end_ff <= end_cond;
			run_ff      <= converting_ff;
		end
	end

	chk_acten_clear: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		end_cond |=> !acten_ff[`ADCTC_BIT_ACTEN])
		else $error("activation enable not cleared");
	chk_end_pulse: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		end_cond |=> xfer_end_ff)
		else $error("transfer end missing");
	chk_count_reload: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		(state_ff == adctc_pkg::ST_DONE && is_rpt && cnt_last) |=> count_ff == $past(reload_ff))
		else $error("count not reloaded");
	chk_count_dec: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		(state_ff == adctc_pkg::ST_DONE && !cnt_last && !wr_hit) |=> count_ff == $past(count_ff) - 8'h01)
		else $error("count not decremented");
	chk_src_fixed: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		(state_ff == adctc_pkg::ST_READ && !src_inc && !rpt_src && !wr_hit) |=> $stable(src_ff))
		else $error("source moved while fixed");
	chk_start_gate: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		(state_ff == adctc_pkg::ST_IDLE && !acten_ff[`ADCTC_BIT_ACTEN]) |=> state_ff == adctc_pkg::ST_IDLE)
		else $error("started while disabled");
	chk_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		ce_rise |=> irqf_ff[`ADCTC_BIT_CEFLAG])
		else $error("request flag not set");
	chk_mask_block: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		(irqm_ff[`ADCTC_BIT_CEMASK] && evstat_ff == 2'b00 && $stable(irqm_ff)) |=> !irq_ff)
		else $error("masked request raised irq");
	chk_src_repeat: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		(state_ff == adctc_pkg::ST_READ && mem_ack && rpt_src && !wr_hit)
		|=> src_ff == $past(src_ff) + $past(step))
		else $error("repeat source did not step");
	chk_dst_hold: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		(state_ff == adctc_pkg::ST_WRITE && rpt_src && !wr_hit) |=> $stable(dst_ff))
		else $error("destination moved while source repeats");
	chk_rpt_return: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		(state_ff == adctc_pkg::ST_DONE && rpt_src && cnt_last)
		|=> src_ff == $past(src_base_ff))
		else $error("repeat source not returned");
	chk_units_full: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		(state_ff == adctc_pkg::ST_IDLE && start && blksz_ff == 8'h00)
		|=> units_ff == 9'h100)
		else $error("block of 00 not 256 units");
	chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		(irqf_ff[`ADCTC_BIT_CEFLAG] && !irqm_ff[`ADCTC_BIT_CEMASK]) |=> irq_ff)
		else $error("unmasked request without irq");
	chk_run_wait: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
		(stab_ff != 8'h00) |-> ##2 !run_ff)
		else $error("run shown inside stabilisation wait");
endmodule

// *** testbench/adctc_mem_model.sv ***
module adctc_mem_model (
	input  wire logic                  clk_sys,
	input  wire adctc_pkg::adctc_mem_t mem_ff,
	input  wire logic [3:0]            lat,
	output logic                       mem_ack,
	output logic [15:0]                mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0]  wait_cnt;
	// Log of accepted writes: {wide, addr, wdata}
	logic [32:0] wlog[$];
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 16'hFFFF;
		wait_cnt = 4'h0;
	end
	// Read data is a function of the address, so the bench can tell which source was read
	// Outside an ack the data toggles every cycle, so a design that samples late sees junk
	always @(posedge clk_sys) begin
		if (mem_ff.req && !mem_ack && wait_cnt == lat) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem_ff.addr ^ 16'h5A5A;
			wait_cnt <= 4'h0;
			if (mem_ff.we) begin
				wlog.push_back({mem_ff.wide, mem_ff.addr, mem_ff.wdata});
			end
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_cnt <= (mem_ff.req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
		end
	end
endmodule

// *** testbench/adctc_channel_test.sv ***
`include "adctc_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module adctc_channel_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  clk_sys;
	logic                  rst_n;
	adctc_pkg::adctc_bus_t bus_in;
	logic [7:0]            rdata_ff;
	logic                  conv_end;
	logic                  mem_ack;
	logic [15:0]           mem_rdata;
	adctc_pkg::adctc_mem_t mem_ff;
	logic                  irq_ff;
	logic                  xfer_end_ff;
	logic                  run_ff;
	logic [3:0]            lat;
	int                    n_mismatch;
	int                    cmp_count;
	int                    n_end;
	int                    cyc;
	adctc_channel u_adctc_channel (.clk_sys(clk_sys), .rst_n(rst_n), .bus_in(bus_in),
		.rdata_ff(rdata_ff), .conv_end(conv_end), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.mem_ff(mem_ff), .irq_ff(irq_ff), .xfer_end_ff(xfer_end_ff), .run_ff(run_ff));
	adctc_mem_model u_adctc_mem_model (.clk_sys(clk_sys), .mem_ff(mem_ff), .lat(lat),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task stop_test();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Transfer end is a one-cycle pulse, so it is counted rather than sampled
	always @(posedge clk_sys) begin
		cyc++;
		if (xfer_end_ff === 1'b1) n_end++;
		if (cyc == 60000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_in <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus_in <= '0;
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		bus_in <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus_in <= '0;
		#1;
		`CHK($sformatf("reg %h", a), e, rdata_ff)
	endtask
	task cfg(input logic [7:0] c, b, n, r, input logic [15:0] s, d);
		wr(`ADCTC_OFS_CTRL, c);
		wr(`ADCTC_OFS_BLKSZ, b);
		wr(`ADCTC_OFS_COUNT, n);
		wr(`ADCTC_OFS_RELOAD, r);
		wr(`ADCTC_OFS_SRC_LO, s[7:0]);
		wr(`ADCTC_OFS_SRC_HI, s[15:8]);
		wr(`ADCTC_OFS_DST_LO, d[7:0]);
		wr(`ADCTC_OFS_DST_HI, d[15:8]);
	endtask
	task fire(input int n);
		u_adctc_mem_model.wlog.delete();
		@(posedge clk_sys);
		conv_end <= 1'b1;
		repeat (4) @(posedge clk_sys);
		conv_end <= 1'b0;
		for (int k = 0; k < 3000 && u_adctc_mem_model.wlog.size() < n; k++) @(posedge clk_sys);
		repeat (8) @(posedge clk_sys);
		`CHK("writes", n, u_adctc_mem_model.wlog.size())
	endtask
	task chkw(input int i, input logic [15:0] da, sa, input logic w);
		logic [32:0] e;
		logic [15:0] m;
		e = u_adctc_mem_model.wlog[i];
		m = w ? 16'hFFFF : 16'h00FF;
		`CHK("wr_addr", da, e[31:16])
		`CHK("wr_wide", w, e[32])
		`CHK("wr_data", (sa ^ 16'h5A5A) & m, e[15:0] & m)
	endtask
	initial begin
		bus_in = '0;
		conv_end = 1'b0;
		rst_n = 1'b0;
		lat = 4'h0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (int a = 0; a < 14; a++) rchk(a[7:0], (a == 10) ? 8'hFF : 8'h00);
		wr(8'h20, 8'h55);
		rchk(8'h20, 8'h00);
		wr(`ADCTC_OFS_CTRL, 8'h10);
		rchk(`ADCTC_OFS_CTRL, 8'h10);
		wr(`ADCTC_OFS_MODE0, 8'h80);
		rchk(`ADCTC_OFS_MODE0, 8'h80);
		repeat (14) @(posedge clk_sys);
		#1;
		`CHK("run_ff", 1'b0, run_ff)
		repeat (12) @(posedge clk_sys);
		#1;
		`CHK("run_ff", 1'b1, run_ff)
		// Activation disabled: event flags only
		cfg(8'h00, 8'h01, 8'h01, 8'h01, 16'h1000, 16'hF500);
		fire(0);
		rchk(`ADCTC_OFS_IRQF, 8'h01);
		`CHK("irq", 1'b0, irq_ff)
		wr(`ADCTC_OFS_IRQM, 8'hFE);
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("irq", 1'b1, irq_ff)
		wr(`ADCTC_OFS_IRQF, 8'h00);
		wr(`ADCTC_OFS_IRQM, 8'hFF);
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("irq", 1'b0, irq_ff)
		rchk(`ADCTC_OFS_IRQF, 8'h00);
		wr(`ADCTC_OFS_EVSTAT, 8'hFF);
		// Normal byte mode, fixed source, repeat select ignored, slow memory
		lat = 4'h3;
		cfg(8'h02, 8'h02, 8'h01, 8'h00, 16'hFF1E, 16'hF500);
		wr(`ADCTC_OFS_ACTEN, 8'h20);
		fire(2);
		chkw(0, 16'hF500, 16'hFF1E, 1'b0);
		chkw(1, 16'hF501, 16'hFF1E, 1'b0);
		`CHK("xfer_end", 1, n_end)
		rchk(`ADCTC_OFS_ACTEN, 8'h00);
		rchk(`ADCTC_OFS_COUNT, 8'h00);
		rchk(`ADCTC_OFS_EVSTAT, 8'h03);
		wr(`ADCTC_OFS_EVMASK, 8'h02);
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("irq", 1'b1, irq_ff)
		wr(`ADCTC_OFS_EVSTAT, 8'h03);
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("irq", 1'b0, irq_ff)
		// Block and count of 00: 256 halfwords, count wraps to FF without end
		lat = 4'h0;
		cfg(8'h44, 8'h00, 8'h00, 8'h00, 16'h1000, 16'h2000);
		wr(`ADCTC_OFS_ACTEN, 8'h20);
		fire(256);
		chkw(0, 16'h2000, 16'h1000, 1'b1);
		chkw(255, 16'h21FE, 16'h11FE, 1'b1);
		rchk(`ADCTC_OFS_COUNT, 8'hFF);
		rchk(`ADCTC_OFS_ACTEN, 8'h20);
		`CHK("xfer_end", 1, n_end)
		// Repeat at source, step bit clear but source still advances, then reloads
		// Destination is not the repeat area here and stays put
		cfg(8'h43, 8'h02, 8'h01, 8'h02, 16'h3000, 16'h4000);
		fire(2);
		chkw(0, 16'h4000, 16'h3000, 1'b1);
		chkw(1, 16'h4000, 16'h3002, 1'b1);
		rchk(`ADCTC_OFS_COUNT, 8'h02);
		rchk(`ADCTC_OFS_SRC_LO, 8'h00);
		rchk(`ADCTC_OFS_DST_LO, 8'h00);
		fire(2);
		chkw(0, 16'h4000, 16'h3000, 1'b1);
		chkw(1, 16'h4000, 16'h3002, 1'b1);
		rchk(`ADCTC_OFS_COUNT, 8'h01);
		rchk(`ADCTC_OFS_SRC_LO, 8'h04);
		`CHK("xfer_end", 1, n_end)
		wr(`ADCTC_OFS_MODE0, 8'h00);
		rchk(`ADCTC_OFS_MODE0, 8'h00);
		stop_test();
	end
endmodule
